/* hw/nvpp_port.sv */
// parallel programming port: command, address and data loading, page
// buffer, timed page program, fuse write, signature and calibration read
// assumes programmer pins already synchronous to aclk; one axi4-lite master
// Notes on behaviour
// - pair 10 plus load strobe loads command
// - pair 01 loads data high or low
// - pair 00, select-one high loads address high
// - page latch stores data word in buffer
// - low address bits word, upper bits page
// - write strobe programs flash page, busy low
// - no-operation command disarms write signals
// - command 11 hex selects eeprom pages
// - write strobe programs eeprom page, busy low
// - fuse write, bit zero programs fuse
// - read command returns signature bytes zero to two
// - read command, select-one high returns calibration
// - busy falls within one microsecond
// - write operations busy 3.7 to 4.5 ms
// - chip erase busy 7.5 to 9 ms
// - pair 00, select-one low loads address low
// - command 10 hex selects flash page write
// - command 80 hex starts chip erase
`default_nettype none

module nvpp_port #(
    parameter int WRITE_CYC = nvpp_pkg::WRITE_CYCLES, // shorten in sim
    parameter int ERASE_CYC = nvpp_pkg::ERASE_CYCLES  // shorten in sim
) (
    input  wire  logic        aclk,
    input  wire  logic        aresetn,
    input  wire  logic [7:0]  awaddr,
    input  wire  logic        awvalid,
    output logic              awready,
    input  wire  logic [31:0] wdata,
    input  wire  logic [3:0]  wstrb,
    input  wire  logic        wvalid,
    output logic              wready,
    output logic [1:0]        bresp,
    output logic              bvalid,
    input  wire  logic        bready,
    input  wire  logic [7:0]  araddr,
    input  wire  logic        arvalid,
    output logic              arready,
    output logic [31:0]       rdata,
    output logic [1:0]        rresp,
    output logic              rvalid,
    input  wire  logic        rready,
    input  wire  logic        load_select_hi,
    input  wire  logic        load_select_lo,
    input  wire  logic        byte_select_one,
    input  wire  logic        byte_select_two,
    input  wire  logic        load_strobe_pin,
    input  wire  logic        page_latch_strobe,
    input  wire  logic        write_strobe_n,
    input  wire  logic        output_enable_n,
    input  wire  logic [7:0]  data_in,
    output logic [7:0]        data_out,
    output logic              data_oe,
    output logic              ready_busy_n
);

    // module state except the busy_len_q helper, registered once per edge
    typedef struct packed {
        logic                      ld_prev;   // load strobe last cycle
        logic                      pl_prev;   // page latch last cycle
        logic                      wr_prev;   // write strobe last cycle
        logic [7:0]                cmd;       // loaded command
        logic                      armed;     // write signals live
        logic [7:0]                addr_lo;
        logic [7:0]                addr_hi;
        logic [7:0]                dat_lo;
        logic [7:0]                dat_hi;
        logic [nvpp_pkg::PAGE_WORDS-1:0][15:0] pbuf; // page buffer
        logic                      busy;
        logic [nvpp_pkg::CNT_W-1:0] cnt;      // busy cycles left
        nvpp_pkg::nvpp_op_t        op;        // last operation
        logic [15:0]               page;      // last programmed page
        logic [7:0]                fuse_lo;
        logic [7:0]                fuse_hi;
        logic [7:0]                dout;
        logic                      doe;
        logic                      en;        // port enable
        logic [7:0]                cal;       // calibration byte
        logic [4:0]                bidx;      // buffer view index
        logic                      aw_held;
        logic [7:0]                aw_addr;
        logic                      w_held;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } nvpp_state_t;

    nvpp_state_t s_q;  // current state
    nvpp_state_t s_d;  // next state

    logic [1:0] sel;      // load-select pair
    logic       live;     // strobes honoured
    logic       ld_go;    // accepted load strobe rise
    logic       pl_go;    // accepted page latch rise
    logic       wr_go;    // accepted write strobe fall
    logic [4:0] widx;     // word index in page
    logic [31:0] rd_word; // read mux

    assign sel = {load_select_hi, load_select_lo};
    // strobes during an operation are dropped rather than queued
    assign live  = s_q.en & ~s_q.busy;
    assign ld_go = live & load_strobe_pin & ~s_q.ld_prev;
    assign pl_go = live & page_latch_strobe & ~s_q.pl_prev;
    assign wr_go = live & ~write_strobe_n & s_q.wr_prev;

    // word select: eeprom pages are narrower than flash pages
    assign widx = (s_q.cmd == nvpp_pkg::CMD_EEPROM)
                ? {3'h0, s_q.addr_lo[nvpp_pkg::EE_WORD_BITS-1:0]}
                : s_q.addr_lo[nvpp_pkg::FLASH_WORD_BITS-1:0];

    // axi handshakes; new write only after the previous response is gone
    assign awready = ~s_q.aw_held & ~s_q.bvalid;
    assign wready  = ~s_q.w_held & ~s_q.bvalid;
    assign arready = ~s_q.rvalid;

    // register outputs
    assign bvalid       = s_q.bvalid;
    assign bresp        = s_q.bresp;
    assign rvalid       = s_q.rvalid;
    assign rdata        = s_q.rdata;
    assign rresp        = s_q.rresp;
    assign data_out     = s_q.dout;
    assign data_oe      = s_q.doe;
    assign ready_busy_n = ~s_q.busy;

    // register read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (araddr)
            nvpp_pkg::OFS_CTRL:     rd_word[0] = s_q.en;
            nvpp_pkg::OFS_STATUS: begin
                rd_word[nvpp_pkg::ST_BUSY]       = s_q.busy;
                rd_word[nvpp_pkg::ST_ARMED]      = s_q.armed;
                rd_word[nvpp_pkg::ST_OP +: 3]    = s_q.op;
                rd_word[nvpp_pkg::ST_CMD +: 8]   = s_q.cmd;
            end
            nvpp_pkg::OFS_PAGE:     rd_word[15:0] = s_q.page;
            nvpp_pkg::OFS_FUSE:     rd_word[15:0] = {s_q.fuse_hi, s_q.fuse_lo};
            nvpp_pkg::OFS_BUF_IDX:  rd_word[4:0] = s_q.bidx;
            nvpp_pkg::OFS_BUF_DATA: rd_word[15:0] = s_q.pbuf[s_q.bidx];
            nvpp_pkg::OFS_CAL:      rd_word[7:0] = s_q.cal;
            default:                rd_word = 32'h0000_0000;
        endcase
    end

    // next-state logic for pins, timer and bus
    always_comb begin
        s_d = s_q;
        s_d.ld_prev = load_strobe_pin;
        s_d.pl_prev = page_latch_strobe;
        s_d.wr_prev = write_strobe_n;

        // busy countdown; ends exactly after the loaded count
        if (s_q.busy) begin
            if (s_q.cnt == nvpp_pkg::CNT_W'(1)) begin
                s_d.busy = 1'b0;
            end
            s_d.cnt = s_q.cnt - nvpp_pkg::CNT_W'(1);
        end

        // load strobe: command, address or data byte
        if (ld_go) begin
            unique case (sel)
                nvpp_pkg::SEL_CMD: begin
                    s_d.cmd   = data_in;
                    // no-op drops the write signals, others arm them
                    s_d.armed = (data_in != nvpp_pkg::CMD_NOP);
                end
                nvpp_pkg::SEL_DATA: begin
                    if (byte_select_one) begin
                        s_d.dat_hi = data_in;
                    end else begin
                        s_d.dat_lo = data_in;
                    end
                end
                nvpp_pkg::SEL_ADDR: begin
                    if (byte_select_one) begin
                        s_d.addr_hi = data_in;
                    end else begin
                        s_d.addr_lo = data_in;
                    end
                end
                default: ;  // pair 11 is not a load code
            endcase
        end

        // page latch: data word into buffer slot
        if (pl_go && byte_select_one) begin
            s_d.pbuf[widx] = {s_q.dat_hi, s_q.dat_lo};
        end

        // write strobe fall starts the timed operation
        if (wr_go && s_q.armed) begin
            if (s_q.cmd == nvpp_pkg::CMD_FUSE) begin
                // written value: 0 programs, 1 erases, stored as given
                if (byte_select_one && !byte_select_two) begin
                    s_d.fuse_hi = s_q.dat_lo;
                end else if (!byte_select_one && !byte_select_two) begin
                    s_d.fuse_lo = s_q.dat_lo;
                end
                s_d.busy = 1'b1;
                s_d.cnt  = nvpp_pkg::CNT_W'(WRITE_CYC);
                s_d.op   = nvpp_pkg::OP_FUSE;
            end else if (!byte_select_one) begin
                if (s_q.cmd == nvpp_pkg::CMD_FLASH) begin
                    s_d.page = {5'h00, s_q.addr_hi,
                                s_q.addr_lo[7:nvpp_pkg::FLASH_WORD_BITS]};
                    s_d.busy = 1'b1;
                    s_d.cnt  = nvpp_pkg::CNT_W'(WRITE_CYC);
                    s_d.op   = nvpp_pkg::OP_FLASH;
                end else if (s_q.cmd == nvpp_pkg::CMD_EEPROM) begin
                    s_d.page = {2'h0, s_q.addr_hi,
                                s_q.addr_lo[7:nvpp_pkg::EE_WORD_BITS]};
                    s_d.busy = 1'b1;
                    s_d.cnt  = nvpp_pkg::CNT_W'(WRITE_CYC);
                    s_d.op   = nvpp_pkg::OP_EEPROM;
                end else if (s_q.cmd == nvpp_pkg::CMD_ERASE) begin
                    // erased cells read back as all ones
                    s_d.pbuf = '1;
                    s_d.busy = 1'b1;
                    s_d.cnt  = nvpp_pkg::CNT_W'(ERASE_CYC);
                    s_d.op   = nvpp_pkg::OP_ERASE;
                end
            end
        end

        // read path: registered, well inside the 250 ns budget
        s_d.doe  = 1'b0;
        s_d.dout = 8'h00;
        if (!output_enable_n && s_q.en
            && s_q.cmd == nvpp_pkg::CMD_READ_SIG) begin
            if (!byte_select_one) begin
                unique case (s_q.addr_lo)
                    8'h00: s_d.dout = nvpp_pkg::SIG_BYTE0;
                    8'h01: s_d.dout = nvpp_pkg::SIG_BYTE1;
                    8'h02: s_d.dout = nvpp_pkg::SIG_BYTE2;
                    default: s_d.dout = 8'h00;
                endcase
                s_d.doe = (s_q.addr_lo <= 8'(nvpp_pkg::SIG_LAST));
            end else if (s_q.addr_lo == 8'h00) begin
                s_d.dout = s_q.cal;
                s_d.doe  = 1'b1;
            end
        end

        // axi write channels, taken in either order
        if (awvalid && awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        if (s_q.aw_held && s_q.w_held) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = nvpp_pkg::RESP_OKAY;
            unique case (s_q.aw_addr)
                nvpp_pkg::OFS_CTRL: begin
                    if (s_q.w_strb[0]) s_d.en = s_q.w_data[0];
                end
                nvpp_pkg::OFS_BUF_IDX: begin
                    if (s_q.w_strb[0]) s_d.bidx = s_q.w_data[4:0];
                end
                nvpp_pkg::OFS_CAL: begin
                    if (s_q.w_strb[0]) s_d.cal = s_q.w_data[7:0];
                end
                nvpp_pkg::OFS_STATUS, nvpp_pkg::OFS_PAGE,
                nvpp_pkg::OFS_FUSE, nvpp_pkg::OFS_BUF_DATA: ; // read only
                default: s_d.bresp = nvpp_pkg::RESP_SLVERR;
            endcase
        end else if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        // axi read: one cycle from address to data
        if (arvalid && arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_word;
            s_d.rresp  = (araddr > nvpp_pkg::OFS_CAL || araddr[1:0] != 2'h0)
                       ? nvpp_pkg::RESP_SLVERR : nvpp_pkg::RESP_OKAY;
        end else if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q         <= '0;
            s_q.ld_prev <= 1'b1;  // no false edge at release
            s_q.wr_prev <= 1'b1;
            s_q.pl_prev <= 1'b1;
            s_q.pbuf    <= '1;
            s_q.en      <= nvpp_pkg::CTRL_EN_RST;
            s_q.fuse_lo <= nvpp_pkg::FUSE_RST;
            s_q.fuse_hi <= nvpp_pkg::FUSE_RST;
            s_q.cal     <= nvpp_pkg::CAL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // helper: length of the busy run just ended
    logic [nvpp_pkg::CNT_W-1:0] busy_len_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !s_q.busy) begin
            busy_len_q <= s_q.busy ? busy_len_q : '0;
        end
        if (!aresetn) begin
            busy_len_q <= '0;
        end else if (s_q.busy) begin
            busy_len_q <= busy_len_q + nvpp_pkg::CNT_W'(1);
        end else if (!s_d.busy) begin
            busy_len_q <= '0;
        end
    end

    localparam int BF = 20;  // busy fall bound in cycles

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_cmd_load: assert property (ld_go && sel == nvpp_pkg::SEL_CMD
        |=> s_q.cmd == $past(data_in)) else $error("command not loaded");
    a_data_hi: assert property (ld_go && sel == nvpp_pkg::SEL_DATA
        && byte_select_one |=> s_q.dat_hi == $past(data_in))
        else $error("data high not loaded");
    a_addr_hi: assert property (ld_go && sel == nvpp_pkg::SEL_ADDR
        && byte_select_one |=> s_q.addr_hi == $past(data_in))
        else $error("address high not loaded");
    a_addr_lo: assert property (ld_go && sel == nvpp_pkg::SEL_ADDR
        && !byte_select_one |=> s_q.addr_lo == $past(data_in))
        else $error("address low not loaded");
    a_page_latch: assert property (pl_go && byte_select_one
        |=> s_q.pbuf[$past(widx)] == {$past(s_q.dat_hi), $past(s_q.dat_lo)})
        else $error("page buffer word not stored");
    a_busy_fall: assert property (wr_go && s_q.armed && !byte_select_one
        && s_q.cmd == nvpp_pkg::CMD_FLASH |-> ##[1:BF] !ready_busy_n)
        else $error("busy late after write strobe");
    a_write_len: assert property ($fell(s_q.busy)
        && s_q.op != nvpp_pkg::OP_ERASE |-> busy_len_q == WRITE_CYC)
        else $error("write busy length wrong");
    a_erase_len: assert property ($fell(s_q.busy)
        && s_q.op == nvpp_pkg::OP_ERASE |-> busy_len_q == ERASE_CYC)
        else $error("erase busy length wrong");
    a_nop_disarm: assert property (ld_go && sel == nvpp_pkg::SEL_CMD
        && data_in == nvpp_pkg::CMD_NOP |=> !s_q.armed ##1 !s_q.busy)
        else $error("no-op left write armed");
    a_sig_read: assert property (!output_enable_n && s_q.en
        && !byte_select_one && s_q.cmd == nvpp_pkg::CMD_READ_SIG
        && s_q.addr_lo == 8'h01 && $stable(s_q.addr_lo)
        |=> data_oe && data_out == nvpp_pkg::SIG_BYTE1)
        else $error("signature byte not driven");
    a_cal_read: assert property (!output_enable_n && s_q.en
        && byte_select_one && s_q.cmd == nvpp_pkg::CMD_READ_SIG
        && s_q.addr_lo == 8'h00 |=> data_oe && data_out == $past(s_q.cal))
        else $error("calibration byte not driven");
    a_fuse_hi: assert property (wr_go && s_q.armed
        && s_q.cmd == nvpp_pkg::CMD_FUSE && byte_select_one
        && !byte_select_two |=> s_q.fuse_hi == $past(s_q.dat_lo)
        && s_q.busy) else $error("high fuse not written");

endmodule

`default_nettype wire

/* hw/nvpp_pkg.sv */
// constants for the parallel programming port of the on-chip nvm
// assumes a 20 mhz aclk and an axi4-lite master with 8-bit addresses
`default_nettype none

package nvpp_pkg;

    // load-select pair codes {hi, lo}
    localparam logic [1:0] SEL_ADDR = 2'h0;  // address byte
    localparam logic [1:0] SEL_DATA = 2'h1;  // data byte
    localparam logic [1:0] SEL_CMD  = 2'h2;  // command byte

    // command codes
    localparam logic [7:0] CMD_NOP      = 8'h00;
    localparam logic [7:0] CMD_READ_SIG = 8'h08;
    localparam logic [7:0] CMD_FLASH    = 8'h10;
    localparam logic [7:0] CMD_EEPROM   = 8'h11;
    localparam logic [7:0] CMD_FUSE     = 8'h40;
    localparam logic [7:0] CMD_ERASE    = 8'h80;

    // page geometry: word index bits inside the address low byte
    localparam int FLASH_WORD_BITS = 5;
    localparam int EE_WORD_BITS    = 2;
    localparam int PAGE_WORDS      = 32;
    localparam int SIG_LAST        = 2;   // highest signature index

    // timing, as printed, then derived cycle counts
    localparam real CLK_MHZ           = 20.0;
    localparam real T_WRITE_MIN_MS    = 3.7;
    localparam real T_WRITE_MAX_MS    = 4.5;
    localparam real T_ERASE_MIN_MS    = 7.5;
    localparam real T_ERASE_MAX_MS    = 9.0;
    localparam real T_BUSY_FALL_MAX_US = 1.0;
    // rounded, since the product is not exact in floating point
    localparam int WRITE_CYCLES =
        int'(T_WRITE_MIN_MS * 1000.0 * CLK_MHZ);
    localparam int ERASE_CYCLES =
        int'($ceil(T_ERASE_MIN_MS * 1000.0 * CLK_MHZ));
    localparam int BUSY_FALL_CYCLES =
        int'($floor(T_BUSY_FALL_MAX_US * CLK_MHZ));
    localparam int CNT_W = 18;            // holds ERASE_CYCLES

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_PAGE     = 8'h08;
    localparam logic [7:0] OFS_FUSE     = 8'h0C;
    localparam logic [7:0] OFS_BUF_IDX  = 8'h10;
    localparam logic [7:0] OFS_BUF_DATA = 8'h14;
    localparam logic [7:0] OFS_CAL      = 8'h18;

    // status field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_OP    = 4;
    localparam int ST_CMD   = 8;

    // reset values
    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [7:0] FUSE_RST    = 8'hFF;
    localparam logic [7:0] CAL_RST     = 8'h80;

    // identity bytes: arbitrary neutral values
    localparam logic [7:0] SIG_BYTE0 = 8'h5A;
    localparam logic [7:0] SIG_BYTE1 = 8'hA5;
    localparam logic [7:0] SIG_BYTE2 = 8'h3C;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // last operation started, kept after busy ends
    typedef enum logic [2:0] {
        OP_IDLE, OP_FLASH, OP_EEPROM, OP_FUSE, OP_ERASE
    } nvpp_op_t;

endpackage

`default_nettype wire

/* verification/nvpp_prog.sv */
// programmer model: drives the parallel pins with slow strobes
// assumes tasks are called by the bench; pins move after rising aclk
`default_nettype none
module nvpp_prog (
    input  wire logic       aclk,
    input  wire logic       ready_busy_n,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output var  logic       load_select_hi,
    output var  logic       load_select_lo,
    output var  logic       byte_select_one,
    output var  logic       byte_select_two,
    output var  logic       load_strobe_pin,
    output var  logic       page_latch_strobe,
    output var  logic       write_strobe_n,
    output var  logic       output_enable_n,
    output var  logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobes idle from time zero
    initial begin
        {load_select_hi, load_select_lo, byte_select_one} = 3'h0;
        {byte_select_two, load_strobe_pin, page_latch_strobe} = 3'h0;
        {write_strobe_n, output_enable_n} = 2'h3;
        data_in = 8'hA5;
    end
    // selects and data settle one edge before the strobe
    task automatic load(input logic [1:0] s, input logic b1,
                        input logic [7:0] d);
        {load_select_hi, load_select_lo} <= s;
        byte_select_one <= b1;
        data_in <= d;
        @(posedge aclk);
        load_strobe_pin <= 1'b1;
        repeat (3) @(posedge aclk);
        load_strobe_pin <= 1'b0;
        @(posedge aclk);
        data_in <= ~d;  // released bus must not keep its value
        @(posedge aclk);
    endtask
    // page latch with high byte select held across the pulse
    task automatic latch();
        byte_select_one <= 1'b1;
        @(posedge aclk);
        page_latch_strobe <= 1'b1;
        repeat (3) @(posedge aclk);
        page_latch_strobe <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    // write pulse; reports cycles to busy and busy length
    task automatic wr(input logic b1, input logic b2,
                      output int fall, output int len);
        byte_select_one <= b1;
        byte_select_two <= b2;
        @(posedge aclk);
        write_strobe_n <= 1'b0;
        fall = 0;
        do begin
            @(negedge aclk);
            fall++;
        end while (ready_busy_n !== 1'b0 && fall < 30);
        len = (ready_busy_n === 1'b0) ? 1 : 0;
        // nothing else is strobed until ready returns
        while (1) begin
            @(posedge aclk);
            write_strobe_n <= 1'b1;
            @(negedge aclk);
            if (len == 0 || ready_busy_n !== 1'b0) break;
            len++;
            if (len > 200) testbench.fail_out();
        end
        @(posedge aclk);
    endtask
    // output enable pulse, sampled once the device has answered
    task automatic rd(input logic b1, output logic [7:0] d,
                      output logic oe);
        byte_select_one <= b1;
        output_enable_n <= 1'b0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        d = data_out;
        oe = data_oe;
        @(posedge aclk);
        output_enable_n <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// bench: axi4-lite master plus programmer model around the port
// assumes shortened program times; all waits are bounded
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WC = 40;  // short write time keeps the run brief
    localparam int EC = 80;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, data_oe, oe;
    logic        load_select_hi, load_select_lo, byte_select_one;
    logic        byte_select_two, load_strobe_pin, page_latch_strobe;
    logic        write_strobe_n, output_enable_n, ready_busy_n;
    logic [7:0]  awaddr, araddr, data_in, data_out, b, ahi, alo, dlo, dhi;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          error_cnt, num_checks, fall, len;
    nvpp_port #(.WRITE_CYC(WC), .ERASE_CYC(EC)) dut_u (.aclk, .aresetn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .load_select_hi, .load_select_lo,
        .byte_select_one, .byte_select_two, .load_strobe_pin,
        .page_latch_strobe, .write_strobe_n, .output_enable_n, .data_in,
        .data_out, .data_oe, .ready_busy_n);
    nvpp_prog prog_u (.aclk, .ready_busy_n, .data_out, .data_oe,
        .load_select_hi, .load_select_lo, .byte_select_one,
        .byte_select_two, .load_strobe_pin, .page_latch_strobe,
        .write_strobe_n, .output_enable_n, .data_in);
    initial aclk = 1'b0;
    always #25 aclk = ~aclk;
    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic fail_out();
        $display("[FAIL] %0t wait bound used up", $time);
        error_cnt++;
        report_and_stop();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // master: either channel may be taken first, response after both
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int   n = 0;
        logic pa = 1'b1;
        logic pw = 1'b1;
        logic bv;
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(negedge aclk);
            if (++n > 20) fail_out();
            pa = pa && !awready;
            pw = pw && !wready;
            {bv, r} = {bvalid === 1'b1, bresp};
            @(posedge aclk);
            {awvalid, wvalid} <= {pa, pw};
        end while (!bv);
        bready <= 1'b0;
        chk(r, nvpp_pkg::RESP_OKAY);
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int   n = 0;
        logic pa = 1'b1;
        logic rv;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(negedge aclk);
            if (++n > 20) fail_out();
            pa = pa && !arready;
            {rv, v, r} = {rvalid === 1'b1, rdata, rresp};
            @(posedge aclk);
            arvalid <= pa;
        end while (!rv);
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a);
        chk(r, nvpp_pkg::RESP_OKAY);
        chk(v, e);
    endtask
    // page number expected from the two address bytes
    function automatic logic [31:0] fpage(logic [7:0] h, logic [7:0] l);
        return {21'h0, h, l[7:5]};
    endfunction
    // one write pulse of a command, busy length compared
    task automatic op(input logic [7:0] c, input logic b1, input int w);
        prog_u.wr(b1, 1'b0, fall, len);
        chk(fall <= nvpp_pkg::BUSY_FALL_CYCLES || w == 0, 1);
        chk(len, w);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        void'($urandom(32'h9786_c4a4));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk(nvpp_pkg::OFS_CTRL, 32'h1);
        rchk(nvpp_pkg::OFS_FUSE, 32'h0000_FFFF);
        axi_rd(8'h1C);
        chk(r, nvpp_pkg::RESP_SLVERR);
        prog_u.load(nvpp_pkg::SEL_CMD, 1'b0, nvpp_pkg::CMD_FLASH);
        for (int p = 0; p < 2; p++) begin
            b = 8'($urandom);
            for (int k = 0; k < 3; k++) begin
                alo = {b[2:0], k == 0 ? 5'h00 : k == 1 ? 5'h1F : 5'($urandom)};
                {dlo, dhi} = 16'($urandom);
                prog_u.load(nvpp_pkg::SEL_ADDR, 1'b0, alo);
                prog_u.load(nvpp_pkg::SEL_DATA, 1'b0, dlo);
                prog_u.load(nvpp_pkg::SEL_DATA, 1'b1, dhi);
                prog_u.latch();
                axi_wr(nvpp_pkg::OFS_BUF_IDX, {27'h0, alo[4:0]});
                rchk(nvpp_pkg::OFS_BUF_DATA, {16'h0, dhi, dlo});
            end
            ahi = 8'($urandom);
            prog_u.load(nvpp_pkg::SEL_ADDR, 1'b1, ahi);
            op(nvpp_pkg::CMD_FLASH, 1'b0, WC);
            rchk(nvpp_pkg::OFS_PAGE, fpage(ahi, alo));
        end
        prog_u.load(nvpp_pkg::SEL_CMD, 1'b0, nvpp_pkg::CMD_EEPROM);
        prog_u.load(nvpp_pkg::SEL_ADDR, 1'b1, ahi);
        prog_u.load(nvpp_pkg::SEL_ADDR, 1'b0, alo);
        prog_u.load(nvpp_pkg::SEL_DATA, 1'b0, dlo);
        prog_u.latch();
        op(nvpp_pkg::CMD_EEPROM, 1'b0, WC);
        rchk(nvpp_pkg::OFS_PAGE, {18'h0, ahi, alo[7:2]});
        prog_u.load(nvpp_pkg::SEL_CMD, 1'b0, nvpp_pkg::CMD_ERASE);
        op(nvpp_pkg::CMD_ERASE, 1'b0, EC);
        rchk(nvpp_pkg::OFS_BUF_DATA, 32'h0000_FFFF);
        prog_u.load(nvpp_pkg::SEL_CMD, 1'b0, nvpp_pkg::CMD_FUSE);
        prog_u.load(nvpp_pkg::SEL_DATA, 1'b0, dhi);
        op(nvpp_pkg::CMD_FUSE, 1'b1, WC);
        rchk(nvpp_pkg::OFS_FUSE, {16'h0, dhi, 8'hFF});
        prog_u.load(nvpp_pkg::SEL_CMD, 1'b0, nvpp_pkg::CMD_NOP);
        op(nvpp_pkg::CMD_NOP, 1'b0, 0);
        prog_u.load(nvpp_pkg::SEL_CMD, 1'b0, nvpp_pkg::CMD_READ_SIG);
        for (int i = 0; i < 3; i++) begin
            prog_u.load(nvpp_pkg::SEL_ADDR, 1'b0, 8'(i));
            prog_u.rd(1'b0, b, oe);
            chk({oe, b}, {1'b1, i == 0 ? nvpp_pkg::SIG_BYTE0 : i == 1 ?
                nvpp_pkg::SIG_BYTE1 : nvpp_pkg::SIG_BYTE2});
        end
        dlo = 8'($urandom);
        axi_wr(nvpp_pkg::OFS_CAL, {24'h0, dlo});
        prog_u.load(nvpp_pkg::SEL_ADDR, 1'b0, 8'h00);
        prog_u.rd(1'b1, b, oe);
        chk({oe, b}, {1'b1, dlo});
        report_and_stop();
    end
endmodule
`default_nettype wire
